// ---- inc/reid_pkg.sv ----
// Constants shared by the radio event interrupt-enable block.
// Assumes a 32-bit AHB-Lite register bus and single-cycle event pulses.
package reid_pkg;
	localparam int DW = 32;
	localparam int AW = 12;

	// Register byte offsets
	localparam logic [11:0] OFS_EVT_STAT = 12'h000;
	localparam logic [11:0] OFS_EN_SET = 12'h004;
	localparam logic [11:0] OFS_EN_CLR = 12'h008;
	localparam logic [11:0] OFS_MODE_CFG = 12'h00c;

	// Event field positions, shared by status, enable-set and enable-clear
	localparam int BIT_CCA_IDLE = 17;
	localparam int BIT_CCA_BUSY = 18;
	localparam int BIT_CCA_HALTED = 19;
	localparam int BIT_LR_SPEEDUP = 20;
	localparam int BIT_TX_RAMP = 21;
	localparam int BIT_RX_RAMP = 22;
	localparam int BIT_MAC_HIT = 23;
	localparam int BIT_SYNC = 26;
	localparam int BIT_PHY_OVER = 27;

	localparam logic [31:0] FIELD_MASK = 32'h0cfe0000;
	localparam logic [31:0] MASK_CCA = 32'h000e0000;
	localparam logic [31:0] MASK_TX_RAMP = 32'h00200000;
	localparam logic [31:0] MASK_RX_RAMP = 32'h00400000;
	localparam logic [31:0] MASK_MAC_PHY = 32'h08800000;

	// Reset values
	localparam logic [31:0] RST_ENABLE = 32'h00000000;
	localparam logic [31:0] RST_STATUS = 32'h00000000;
	localparam logic [1:0] RST_MODE = 2'h0;

	// Receive mode field of the mode register, bits [1:0]; live rate in [5:4]
	localparam logic [1:0] MODE_OTHER = 2'h0;
	localparam logic [1:0] MODE_LR_SLOW = 2'h1;
	localparam logic [1:0] MODE_LR_FAST = 2'h2;
	localparam logic [1:0] MODE_PAN = 2'h3;
	localparam int MODE_LSB = 0;
	localparam int RATE_LSB = 4;

	// Bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
endpackage

// ---- src/reid_evt_sticky.sv ----
// Sticky event status bits, one per implemented event field.
// Assumes set and clear vectors are single-cycle strobes in the CLK domain.
`timescale 1ns/100ps
module reid_evt_sticky (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Strobes
	input wire logic [31:0] set_i,
	input wire logic [31:0] clr_i,
	// State
	output logic [31:0] stat_o
);
	genvar gi;
	generate
		for (gi = 0; gi < reid_pkg::DW; gi++) begin : g_bit
			if (reid_pkg::FIELD_MASK[gi]) begin : g_impl
				logic bit_q;
				// A clear in the cycle of a new event must not lose it
				always_ff @(posedge clk or negedge rst_b) begin
					if (!rst_b) begin
						bit_q <= reid_pkg::RST_STATUS[gi];
					end else begin
						bit_q <= set_i[gi] | (bit_q & ~clr_i[gi]);
					end
				end
				assign stat_o[gi] = bit_q;
			end else begin : g_rsvd
				assign stat_o[gi] = 1'b0;
			end
		end
	endgenerate

	a_set_wins_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(set_i & reid_pkg::FIELD_MASK) != 32'h00000000 |=>
		(stat_o & $past(set_i) & reid_pkg::FIELD_MASK) == ($past(set_i) & reid_pkg::FIELD_MASK))
		else $error("event lost against a clear");
	c_set_and_clear: cover property (@(posedge clk) disable iff (!rst_b)
		(set_i & clr_i) != 32'h00000000);
endmodule // reid_evt_sticky

// ---- src/reid_lr_evt.sv ----
// Receive-rate tracker raising the speed-up and preamble-hint events.
// Assumes rx_active frames one receive transaction and ci_* come from the demodulator.
`timescale 1ns/100ps
module reid_lr_evt (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Configuration
	input wire logic [1:0] mode_i,
	// Receiver status
	input wire logic rx_active,
	input wire logic ci_valid,
	input wire logic ci_fast,
	input wire logic preamble_hint,
	// Events and state
	output logic speedup_q,
	output logic sync_q,
	output logic [1:0] rate_o
);
	typedef enum logic [2:0] {RATE_IDLE, RATE_OTHER, RATE_SLOW, RATE_FAST, RATE_PAN} reid_rate_t;
	reid_rate_t state_q;
	logic boost;
	logic hint_ok;

	assign boost = rx_active && ci_valid && ci_fast && (state_q == RATE_SLOW);
	assign hint_ok = rx_active && preamble_hint &&
		(state_q == RATE_SLOW || state_q == RATE_FAST || state_q == RATE_PAN);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= RATE_IDLE;
		end else if (!rx_active) begin
			state_q <= RATE_IDLE;
		end else begin
			case (state_q)
				RATE_IDLE: begin
					case (mode_i)
						reid_pkg::MODE_LR_SLOW: state_q <= RATE_SLOW;
						reid_pkg::MODE_LR_FAST: state_q <= RATE_FAST;
						reid_pkg::MODE_PAN: state_q <= RATE_PAN;
						default: state_q <= RATE_OTHER;
					endcase
				end
				RATE_SLOW: begin
					if (boost) begin
						state_q <= RATE_FAST;
					end
				end
				default: state_q <= state_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			speedup_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			speedup_q <= boost;
			sync_q <= hint_ok;
		end
	end

	always_comb begin
		case (state_q)
			RATE_SLOW: rate_o = reid_pkg::MODE_LR_SLOW;
			RATE_FAST: rate_o = reid_pkg::MODE_LR_FAST;
			RATE_PAN: rate_o = reid_pkg::MODE_PAN;
			default: rate_o = reid_pkg::MODE_OTHER;
		endcase
	end

	a_speedup_switch: assert property (@(posedge clk) disable iff (!rst_b)
		boost |=> speedup_q && state_q == RATE_FAST)
		else $error("speed-up event or rate switch missing");
	a_sync_coded_mode: assert property (@(posedge clk) disable iff (!rst_b)
		sync_q |-> $past(rx_active) && $past(preamble_hint) && $past(state_q) != RATE_OTHER)
		else $error("sync event outside a coded receive");
	a_sync_hint_only: assert property (@(posedge clk) disable iff (!rst_b)
		hint_ok && !ci_valid && $past(rx_active) && rx_active |=> state_q == $past(state_q) || !rx_active)
		else $error("preamble hint altered the rate state");
	c_speedup: cover property (@(posedge clk) disable iff (!rst_b) boost ##1 sync_q);
endmodule // reid_lr_evt

// ---- src/reid_top.sv ----
// Radio event interrupt enable set/clear registers with sticky event status.
// Assumes an AHB-Lite master with word-only single transfers and one-cycle event pulses.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module reid_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Radio event pulses
	input wire logic CHANNEL_CLEAR_IDLE_EVT,
	input wire logic CHANNEL_ASSESS_BUSY_EVT,
	input wire logic CHANNEL_ASSESS_HALTED_EVT,
	input wire logic TRANSMIT_RAMP_DONE_EVT,
	input wire logic RECEIVE_RAMP_DONE_EVT,
	input wire logic MAC_HEADER_HIT_EVT,
	input wire logic PHY_FRAME_OVER_EVT,
	// Receiver status
	input wire logic RX_ACTIVE,
	input wire logic CODING_INDICATOR_VALID,
	input wire logic CODING_INDICATOR_FAST,
	input wire logic PREAMBLE_HINT,
	// Generated events and interrupt
	output logic LONG_RANGE_SPEEDUP_EVT,
	output logic SYNC_HINT_EVT,
	output logic IRQ
);
	// Bus data phase state
	logic dph_valid_q;
	logic dph_write_q;
	logic [11:0] dph_addr_q;
	logic rd_wait_q;
	logic [31:0] hrdata_q;
	logic addr_take;
	logic wr_en;
	logic sel_stat;
	logic sel_set;
	logic sel_clr;
	logic sel_mode;

	// Register state
	logic [31:0] en_q;
	logic [1:0] mode_q;
	logic [31:0] stat;
	logic [31:0] evt_set;
	logic [31:0] stat_clr;
	logic [31:0] en_set;
	logic [31:0] en_clr;
	logic [31:0] rd_mux;
	logic [1:0] rate;
	logic speedup;
	logic sync_hint;

	// Address phase is taken only for word transfers; other sizes are ignored
	assign addr_take = HSEL && HREADY && HTRANS[1] && (HSIZE == reid_pkg::HSIZE_WORD);
	assign wr_en = dph_valid_q && dph_write_q;

	// Register selects, valid through the whole data phase
	assign sel_stat = (dph_addr_q == reid_pkg::OFS_EVT_STAT);
	assign sel_set = (dph_addr_q == reid_pkg::OFS_EN_SET);
	assign sel_clr = (dph_addr_q == reid_pkg::OFS_EN_CLR);
	assign sel_mode = (dph_addr_q == reid_pkg::OFS_MODE_CFG);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			dph_valid_q <= 1'b0;
			dph_write_q <= 1'b0;
			dph_addr_q <= 12'h000;
		end else if (HREADY) begin
			dph_valid_q <= addr_take;
			dph_write_q <= addr_take && HWRITE;
			dph_addr_q <= HADDR[11:0];
		end
	end

	// One wait state on reads lets read data come from a flop with no
	// hazard against a write completing in the same cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_wait_q <= 1'b0;
		end else if (rd_wait_q) begin
			rd_wait_q <= 1'b0;
		end else if (addr_take && !HWRITE) begin
			rd_wait_q <= 1'b1;
		end
	end

	always_comb begin
		case (dph_addr_q)
			reid_pkg::OFS_EVT_STAT: rd_mux = stat;
			reid_pkg::OFS_EN_SET: rd_mux = en_q;
			reid_pkg::OFS_EN_CLR: rd_mux = en_q;
			reid_pkg::OFS_MODE_CFG: begin
				rd_mux = 32'h00000000;
				rd_mux[reid_pkg::MODE_LSB +: 2] = mode_q;
				rd_mux[reid_pkg::RATE_LSB +: 2] = rate;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_wait_q) begin
			hrdata_q <= rd_mux;
		end
	end

	assign HRDATA = hrdata_q;
	assign HREADYOUT = !rd_wait_q;
	assign HRESP = 1'b0;

	// Enable write strobes masked to implemented fields, status clear strobe unmasked; a zero bit never acts
	assign en_set = (wr_en && sel_set) ? (HWDATA & reid_pkg::FIELD_MASK) : 32'h00000000;
	assign en_clr = (wr_en && sel_clr) ? (HWDATA & reid_pkg::FIELD_MASK) : 32'h00000000;
	assign stat_clr = (wr_en && sel_stat) ? HWDATA : 32'h00000000;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			en_q <= reid_pkg::RST_ENABLE;
		end else begin
			en_q <= (en_q | en_set) & ~en_clr;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_q <= reid_pkg::RST_MODE;
		end else if (wr_en && sel_mode) begin
			mode_q <= HWDATA[reid_pkg::MODE_LSB +: 2];
		end
	end

	// The rate tracker looks at the mode only when a receive starts
	reid_lr_evt u_lr_evt (
		.clk(CLK),
		.rst_b(RST_B),
		.mode_i(mode_q),
		.rx_active(RX_ACTIVE),
		.ci_valid(CODING_INDICATOR_VALID),
		.ci_fast(CODING_INDICATOR_FAST),
		.preamble_hint(PREAMBLE_HINT),
		.speedup_q(speedup),
		.sync_q(sync_hint),
		.rate_o(rate)
	);

	// Event vector in the shared field layout
	always_comb begin
		evt_set = 32'h00000000;
		evt_set[reid_pkg::BIT_CCA_IDLE] = CHANNEL_CLEAR_IDLE_EVT;
		evt_set[reid_pkg::BIT_CCA_BUSY] = CHANNEL_ASSESS_BUSY_EVT;
		evt_set[reid_pkg::BIT_CCA_HALTED] = CHANNEL_ASSESS_HALTED_EVT;
		evt_set[reid_pkg::BIT_LR_SPEEDUP] = speedup;
		evt_set[reid_pkg::BIT_TX_RAMP] = TRANSMIT_RAMP_DONE_EVT;
		evt_set[reid_pkg::BIT_RX_RAMP] = RECEIVE_RAMP_DONE_EVT;
		evt_set[reid_pkg::BIT_MAC_HIT] = MAC_HEADER_HIT_EVT;
		evt_set[reid_pkg::BIT_SYNC] = sync_hint;
		evt_set[reid_pkg::BIT_PHY_OVER] = PHY_FRAME_OVER_EVT;
	end

	// Status shows an event one cycle after its pulse; software clears it by writing ones
	reid_evt_sticky u_sticky (
		.clk(CLK),
		.rst_b(RST_B),
		.set_i(evt_set),
		.clr_i(stat_clr),
		.stat_o(stat)
	);

	assign LONG_RANGE_SPEEDUP_EVT = speedup;
	assign SYNC_HINT_EVT = sync_hint;
	// Status records events even while disabled; only the line is gated
	assign IRQ = |(stat & en_q);

	a_cca_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		en_clr != 32'h00000000 && en_set == 32'h00000000 |=>
		(en_q & $past(HWDATA) & reid_pkg::MASK_CCA) == 32'h00000000 &&
		(en_q & ~$past(HWDATA)) == ($past(en_q) & ~$past(HWDATA)))
		else $error("enable clear touched wrong fields");
	a_tx_ramp_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_TX_RAMP) != 32'h00000000 |=>
		((en_q & reid_pkg::MASK_TX_RAMP) == 32'h00000000) [*2] or
		(((en_q & reid_pkg::MASK_TX_RAMP) == 32'h00000000) ##1 ($past(en_set) != 32'h00000000)))
		else $error("transmit ramp enable not cleared");
	a_rx_ramp_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_en && dph_addr_q == reid_pkg::OFS_EN_CLR && HWDATA[reid_pkg::BIT_RX_RAMP] |=>
		!en_q[reid_pkg::BIT_RX_RAMP] && !IRQ || !en_q[reid_pkg::BIT_RX_RAMP])
		else $error("receive ramp enable not cleared");
	a_mac_phy_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_MAC_PHY) != 32'h00000000 |=>
		(en_q & $past(en_clr) & reid_pkg::MASK_MAC_PHY) == 32'h00000000)
		else $error("header-hit or frame-over enable not cleared");
	a_speedup_status: assert property (@(posedge CLK) disable iff (!RST_B)
		speedup |=> stat[reid_pkg::BIT_LR_SPEEDUP])
		else $error("speed-up event not recorded");
	a_sync_status: assert property (@(posedge CLK) disable iff (!RST_B)
		sync_hint && en_q[reid_pkg::BIT_SYNC] && en_clr == 32'h00000000 |=> IRQ)
		else $error("enabled sync event raised no interrupt");
	a_zero_write_idle: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_en && (dph_addr_q == reid_pkg::OFS_EN_SET || dph_addr_q == reid_pkg::OFS_EN_CLR) &&
		HWDATA == 32'h00000000 |=> en_q == $past(en_q))
		else $error("zero write changed enables");
	a_read_enable: assert property (@(posedge CLK) disable iff (!RST_B)
		rd_wait_q && (dph_addr_q == reid_pkg::OFS_EN_SET || dph_addr_q == reid_pkg::OFS_EN_CLR)
		|=> HREADYOUT && HRDATA == en_q)
		else $error("enable read returned wrong value");
	a_read_wait_one: assert property (@(posedge CLK) disable iff (!RST_B)
		addr_take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state not exactly one cycle");

	// Data phase checks
	a_write_no_wait: assert property (@(posedge CLK) disable iff (!RST_B)
		addr_take && HWRITE |=> HREADYOUT)
		else $error("write inserted a wait state");
	a_rdata_hold: assert property (@(posedge CLK) disable iff (!RST_B)
		!rd_wait_q |=> $stable(HRDATA))
		else $error("read data changed outside a read");
	a_read_status: assert property (@(posedge CLK) disable iff (!RST_B)
		rd_wait_q && sel_stat |=> HRDATA == $past(stat))
		else $error("status read returned wrong value");
	a_read_mode: assert property (@(posedge CLK) disable iff (!RST_B)
		rd_wait_q && sel_mode |=>
		HRDATA[reid_pkg::MODE_LSB +: 2] == $past(mode_q) && HRDATA[reid_pkg::RATE_LSB +: 2] == $past(rate))
		else $error("mode read returned wrong value");
	a_read_unmapped: assert property (@(posedge CLK) disable iff (!RST_B)
		rd_wait_q && !sel_stat && !sel_set && !sel_clr && !sel_mode |=> HRDATA == 32'h00000000)
		else $error("unmapped read returned nonzero data");
	a_mode_write: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_en && sel_mode |=> mode_q == $past(HWDATA[reid_pkg::MODE_LSB +: 2]))
		else $error("mode write not taken");

	// Enable and status checks
	a_cca_others_kept: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_CCA) != 32'h00000000 |=>
		(en_q & ~reid_pkg::MASK_CCA) == ($past(en_q) & ~$past(en_clr) & ~reid_pkg::MASK_CCA))
		else $error("channel-assessment clear disturbed other enables");
	a_tx_clear_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_TX_RAMP) != 32'h00000000 |=>
		(stat & en_q & reid_pkg::MASK_TX_RAMP) == 32'h00000000)
		else $error("cleared transmit ramp enable still feeds the interrupt");
	a_rx_clear_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_RX_RAMP) != 32'h00000000 |=>
		(stat & en_q & reid_pkg::MASK_RX_RAMP) == 32'h00000000)
		else $error("cleared receive ramp enable still feeds the interrupt");
	a_mac_phy_kept: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_clr & reid_pkg::MASK_MAC_PHY) != 32'h00000000 |=>
		(en_q & ~reid_pkg::MASK_MAC_PHY) == ($past(en_q) & ~$past(en_clr) & ~reid_pkg::MASK_MAC_PHY))
		else $error("header-hit or frame-over clear disturbed other enables");
	a_speedup_disable: assert property (@(posedge CLK) disable iff (!RST_B)
		en_clr[reid_pkg::BIT_LR_SPEEDUP] |=> !en_q[reid_pkg::BIT_LR_SPEEDUP])
		else $error("speed-up enable not cleared");
	a_sync_disable: assert property (@(posedge CLK) disable iff (!RST_B)
		en_clr[reid_pkg::BIT_SYNC] |=> !en_q[reid_pkg::BIT_SYNC])
		else $error("sync enable not cleared");
	a_sync_recorded: assert property (@(posedge CLK) disable iff (!RST_B)
		sync_hint |=> stat[reid_pkg::BIT_SYNC])
		else $error("sync event not recorded");
	a_set_write: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_en && sel_set |=>
		(en_q & $past(HWDATA) & reid_pkg::FIELD_MASK) == ($past(HWDATA) & reid_pkg::FIELD_MASK))
		else $error("enable set write not taken");
	a_set_others_kept: assert property (@(posedge CLK) disable iff (!RST_B)
		wr_en && sel_set |=> (en_q & ~$past(HWDATA)) == ($past(en_q) & ~$past(HWDATA)))
		else $error("zero bits of an enable set write changed enables");
	a_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		(en_q & ~reid_pkg::FIELD_MASK) == 32'h00000000 && (stat & ~reid_pkg::FIELD_MASK) == 32'h00000000)
		else $error("reserved enable or status bit set");
	a_clear_keeps_status: assert property (@(posedge CLK) disable iff (!RST_B)
		en_clr != 32'h00000000 |=> (stat & $past(stat)) == $past(stat))
		else $error("disabling an event cleared its status");
	a_status_clear: assert property (@(posedge CLK) disable iff (!RST_B)
		stat_clr != 32'h00000000 |=> (stat & $past(stat_clr) & ~$past(evt_set)) == 32'h00000000)
		else $error("status bit not cleared by write of one");
	a_status_keeps_en: assert property (@(posedge CLK) disable iff (!RST_B)
		stat_clr != 32'h00000000 |=> en_q == $past(en_q))
		else $error("status write changed enables");

	c_enable_then_disable: cover property (@(posedge CLK) disable iff (!RST_B)
		en_set != 32'h00000000 ##[1:20] en_clr != 32'h00000000);
	c_irq_raise: cover property (@(posedge CLK) disable iff (!RST_B) $rose(IRQ));
	c_status_clear: cover property (@(posedge CLK) disable iff (!RST_B)
		stat_clr != 32'h00000000 && stat != 32'h00000000);
endmodule // reid_top

// ---- tb/test_radio_event_irq_disable.sv ----
// Self-checking bench for the radio event interrupt enable/disable registers.
// Assumes reid_top as the only AHB-Lite slave, HREADY fed back from HREADYOUT.
`timescale 1ns/100ps
module test_radio_event_irq_disable;
	localparam logic [31:0] A_STAT = {20'h0, reid_pkg::OFS_EVT_STAT};
	localparam logic [31:0] A_SET = {20'h0, reid_pkg::OFS_EN_SET};
	localparam logic [31:0] A_CLR = {20'h0, reid_pkg::OFS_EN_CLR};
	localparam logic [31:0] A_MODE = {20'h0, reid_pkg::OFS_MODE_CFG};
	logic clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, rx_act, ci_v, ci_f, pre, sp_evt, sy_evt;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [6:0] evt;
	int n_errors = 0;
	int n_compared = 0;
	int evt_bit [7] = '{reid_pkg::BIT_CCA_IDLE, reid_pkg::BIT_CCA_BUSY, reid_pkg::BIT_CCA_HALTED,
		reid_pkg::BIT_TX_RAMP, reid_pkg::BIT_RX_RAMP, reid_pkg::BIT_MAC_HIT, reid_pkg::BIT_PHY_OVER};

	reid_top DUT (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .CHANNEL_CLEAR_IDLE_EVT(evt[0]), .CHANNEL_ASSESS_BUSY_EVT(evt[1]),
		.CHANNEL_ASSESS_HALTED_EVT(evt[2]), .TRANSMIT_RAMP_DONE_EVT(evt[3]), .RECEIVE_RAMP_DONE_EVT(evt[4]),
		.MAC_HEADER_HIT_EVT(evt[5]), .PHY_FRAME_OVER_EVT(evt[6]), .RX_ACTIVE(rx_act),
		.CODING_INDICATOR_VALID(ci_v), .CODING_INDICATOR_FAST(ci_f), .PREAMBLE_HINT(pre),
		.LONG_RANGE_SPEEDUP_EVT(sp_evt), .SYNC_HINT_EVT(sy_evt), .IRQ(irq));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bit_chk(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// Ready is sampled between the edges, where outputs are settled, and acted on at the edge
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		logic r;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= reid_pkg::HSIZE_WORD;
		r = 1'b0;
		while (!r) begin
			@(negedge clk);
			r = hreadyout;
			@(posedge clk);
		end
		hsel <= 1'b0;
		htrans <= reid_pkg::HTRANS_IDLE;
		hwdata <= wd;
		r = 1'b0;
		while (!r) begin
			@(negedge clk);
			r = hreadyout;
			rd = hrdata;
			@(posedge clk);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask

	task automatic at_neg(input logic e_irq, input logic e_sp, input logic e_sy);
		@(negedge clk);
		bit_chk(irq, e_irq);
		bit_chk(sp_evt, e_sp);
		bit_chk(sy_evt, e_sy);
		bit_chk(hresp, 1'b0);
		@(posedge clk);
	endtask

	task automatic t_reset();
		rd(A_STAT, 32'h0);
		rd(A_SET, 32'h0);
		rd(A_CLR, 32'h0);
		rd(A_MODE, 32'h0);
		wr(32'h10, 32'hffffffff);
		rd(32'h10, 32'h0);
		rd(A_SET, 32'h0);
	endtask

	// Each group is cleared from a fully enabled state; stray bits outside the fields ride along
	task automatic t_disable();
		logic [31:0] m [7];
		m = '{reid_pkg::MASK_CCA, 32'h1 << reid_pkg::BIT_CCA_BUSY, reid_pkg::MASK_TX_RAMP,
			reid_pkg::MASK_RX_RAMP, reid_pkg::MASK_MAC_PHY, 32'h1 << reid_pkg::BIT_LR_SPEEDUP,
			32'h1 << reid_pkg::BIT_SYNC};
		for (int i = 0; i < 7; i++) begin
			wr(A_SET, reid_pkg::FIELD_MASK);
			wr(A_CLR, 32'h0);
			rd(A_CLR, reid_pkg::FIELD_MASK);
			wr(A_CLR, m[i] | ~reid_pkg::FIELD_MASK);
			rd(A_CLR, reid_pkg::FIELD_MASK & ~m[i]);
			rd(A_SET, reid_pkg::FIELD_MASK & ~m[i]);
		end
	endtask

	task automatic t_irq();
		for (int i = 0; i < 7; i++) begin
			wr(A_CLR, reid_pkg::FIELD_MASK);
			evt <= 7'h1 << i;
			@(posedge clk);
			evt <= 7'h0;
			at_neg(1'b0, 1'b0, 1'b0);
			wr(A_SET, 32'h1 << evt_bit[i]);
			at_neg(1'b1, 1'b0, 1'b0);
			wr(A_CLR, 32'h1 << evt_bit[i]);
			at_neg(1'b0, 1'b0, 1'b0);
			rd(A_STAT, 32'h1 << evt_bit[i]);
			wr(A_STAT, reid_pkg::FIELD_MASK);
		end
	endtask

	task automatic rx_start(input logic [1:0] mode);
		rx_act <= 1'b0;
		wr(A_MODE, {30'h0, mode});
		rx_act <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	task automatic lr(input logic v, input logic f, input logic p, input logic e_irq, input logic e_sp,
		input logic e_sy);
		ci_v <= v;
		ci_f <= f;
		pre <= p;
		@(posedge clk);
		ci_v <= 1'b0;
		ci_f <= 1'b0;
		pre <= 1'b0;
		at_neg(e_irq, e_sp, e_sy);
	endtask

	task automatic t_lr();
		rx_start(reid_pkg::MODE_LR_SLOW);
		wr(A_SET, (32'h1 << reid_pkg::BIT_LR_SPEEDUP) | (32'h1 << reid_pkg::BIT_SYNC));
		lr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		// Status, and so the interrupt, follow the event pulse by one cycle
		lr(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		lr(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		rd(A_MODE, {26'h0, reid_pkg::MODE_LR_FAST, 2'h0, reid_pkg::MODE_LR_SLOW});
		lr(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		rd(A_MODE, {26'h0, reid_pkg::MODE_LR_FAST, 2'h0, reid_pkg::MODE_LR_SLOW});
		rd(A_STAT, (32'h1 << reid_pkg::BIT_LR_SPEEDUP) | (32'h1 << reid_pkg::BIT_SYNC));
		wr(A_STAT, reid_pkg::FIELD_MASK);
		wr(A_CLR, reid_pkg::FIELD_MASK);
		rx_start(reid_pkg::MODE_OTHER);
		lr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		rx_start(reid_pkg::MODE_PAN);
		wr(A_SET, 32'h1 << reid_pkg::BIT_SYNC);
		lr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		at_neg(1'b1, 1'b0, 1'b0);
		wr(A_CLR, 32'h1 << reid_pkg::BIT_SYNC);
		at_neg(1'b0, 1'b0, 1'b0);
		rx_start(reid_pkg::MODE_LR_FAST);
		lr(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		lr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		rx_act <= 1'b0;
		@(posedge clk);
		lr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
	endtask

	initial begin
		rst_b = 1'b0;
		hsel = 1'b0;
		htrans = reid_pkg::HTRANS_IDLE;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = reid_pkg::HSIZE_WORD;
		hwdata = 32'h0;
		evt = 7'h0;
		rx_act = 1'b0;
		ci_v = 1'b0;
		ci_f = 1'b0;
		pre = 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset();
		t_disable();
		t_irq();
		t_lr();
		finish_test();
	end

	// The whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end
endmodule // test_radio_event_irq_disable
